// File: src/iomc_interp.sv
`timescale 1ns/1ps
// Notes on behaviour
// - generic always; application needs configured application
// - output change: code 1672, count 13
// - output selector 1..3, else invalid
// - value 0x0000 off, 0x0100 on
// - only user-defined outputs may be changed
// - alarm reset: code 41099, count 10
// - simple enable: code 41100, count 11
// - enable word high byte 0/1, low zero
// - latch acknowledge: code 41102, count 11
// - acknowledge destination 0x2001 or 0x2101
// - acknowledge byte 1..3 or 0xFF, low zero
// - protected commands: security type 1, valid password
// - get events needs no password
// - application command codes recognised
// - failures use generic error codes only
// - write back last code and status
module iomc_interp
	import iomc_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      srst,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	input  wire logic [15:0]               reg_addr,
	input  wire logic [15:0]               reg_wdata,
	input  wire logic                      cmd_go,
	input  wire logic [31:0]               admin_password,
	input  wire logic [31:0]               operator_password,
	input  wire logic [15:0]               module_dest,
	input  wire logic [iomc_pkg::NUM_APPS-1:0]    app_enabled,
	input  wire logic [iomc_pkg::NUM_OUTPUTS-1:0] user_output_mask,
	output logic [15:0]                    reg_rdata,
	output logic                           cmd_done,
	output logic [iomc_pkg::NUM_OUTPUTS-1:0] user_out,
	output logic                           alarm_reset,
	output logic                           simple_cmd_en,
	output logic [iomc_pkg::NUM_OUTPUTS-1:0] unlatch,
	output logic                           app_cmd,
	output logic                           events_req
);
	import iomc_pkg::*;

	logic [15:0]  code_r;
	logic [15:0]  count_r;
	logic [15:0]  dest_r;
	logic [15:0]  sec_r;
	logic [31:0]  pwd_r;
	logic [15:0]  p1_r;
	logic [15:0]  p2_r;
	logic [15:0]  last_code_r;
	logic [15:0]  status_r;
	logic [15:0]  status_nxt;
	logic [iomc_pkg::NUM_OUTPUTS-1:0] out_hot;
	iomc_state_t  state_r;

	// password check shared by all protected commands
	function automatic logic pwd_ok(input logic [15:0] sec, input logic [31:0] pwd,
		input logic [31:0] adm, input logic [31:0] opr);
		pwd_ok = (sec == SEC_PASSWORD) && ((pwd == adm) || (pwd == opr));
	endfunction

	function automatic logic [NUM_OUTPUTS-1:0] one_hot(input logic [7:0] sel);
		logic [NUM_OUTPUTS-1:0] v;
		v = '0;
		for (int i = 0; i < NUM_OUTPUTS; i++) begin
			if (sel == 8'(i + 1)) begin
				v[i] = 1'b1;
			end
		end
		one_hot = v;
	endfunction

	// selected output as a mask; a select on a call result is not legal
	assign out_hot = one_hot(p1_r[7:0]);

	// register writes from the master; block is locked while a command runs
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			code_r  <= RST_WORD;
			count_r <= RST_WORD;
			dest_r  <= RST_WORD;
			sec_r   <= RST_WORD;
			pwd_r   <= '0;
			p1_r    <= RST_WORD;
			p2_r    <= RST_WORD;
		end else if (reg_wr && state_r == IOMC_IDLE) begin
			case (reg_addr)
				ADDR_CMD_CODE:    code_r  <= reg_wdata;
				ADDR_PARAM_COUNT: count_r <= reg_wdata;
				ADDR_DEST:        dest_r  <= reg_wdata;
				ADDR_SEC_TYPE:    sec_r   <= reg_wdata;
				ADDR_PWD_HI:      pwd_r[31:16] <= reg_wdata;
				ADDR_PWD_LO:      pwd_r[15:0]  <= reg_wdata;
				ADDR_PARAM_ONE:   p1_r    <= reg_wdata;
				ADDR_PARAM_TWO:   p2_r    <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// read data, one cycle after reg_rd; unmapped reads as zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata <= RST_WORD;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_CMD_CODE:    reg_rdata <= code_r;
				ADDR_PARAM_COUNT: reg_rdata <= count_r;
				ADDR_DEST:        reg_rdata <= dest_r;
				ADDR_SEC_TYPE:    reg_rdata <= sec_r;
				ADDR_PWD_HI:      reg_rdata <= pwd_r[31:16];
				ADDR_PWD_LO:      reg_rdata <= pwd_r[15:0];
				ADDR_PARAM_ONE:   reg_rdata <= p1_r;
				ADDR_PARAM_TWO:   reg_rdata <= p2_r;
				ADDR_LAST_CODE:   reg_rdata <= last_code_r;
				ADDR_STATUS:      reg_rdata <= status_r;
				default:          reg_rdata <= RST_WORD;
			endcase
		end
	end

	// command checking; first failing check gives the status
	always_comb begin
		logic app_ok;
		logic prot_ok;
		app_ok  = 1'b0;
		prot_ok = pwd_ok(sec_r, pwd_r, admin_password, operator_password);
		status_nxt = ST_OK;
		case (code_r)
			CMD_SET_OUTPUT: begin
				if (count_r != CNT_SET_OUTPUT) begin
					status_nxt = ST_BAD_COUNT;
				end else if (!prot_ok) begin
					status_nxt = ST_BAD_PASSWORD;
				end else if (p1_r < 16'h0001 || p1_r > 16'(NUM_OUTPUTS)) begin
					status_nxt = ST_BAD_PARAM;
				end else if (p2_r != VAL_OFF && p2_r != VAL_ON) begin
					status_nxt = ST_BAD_PARAM;
				end else if ((one_hot(p1_r[7:0]) & user_output_mask) == '0) begin
					status_nxt = ST_NOT_ASSIGNED;
				end
			end
			CMD_RESET_ALARMS: begin
				if (count_r != CNT_RESET_ALARMS) begin
					status_nxt = ST_BAD_COUNT;
				end else if (!prot_ok) begin
					status_nxt = ST_BAD_PASSWORD;
				end
			end
			CMD_SIMPLE_EN: begin
				if (count_r != CNT_SIMPLE_EN) begin
					status_nxt = ST_BAD_COUNT;
				end else if (!prot_ok) begin
					status_nxt = ST_BAD_PASSWORD;
				end else if (p1_r[15:8] > 8'h01 || p1_r[7:0] != 8'h00) begin
					status_nxt = ST_BAD_PARAM;
				end
			end
			CMD_ACK_LATCH: begin
				if (count_r != CNT_ACK_LATCH) begin
					status_nxt = ST_BAD_COUNT;
				end else if ((dest_r != DEST_MODULE_ONE && dest_r != DEST_MODULE_TWO)
					|| dest_r != module_dest) begin
					status_nxt = ST_BAD_DEST;
				end else if (!prot_ok) begin
					status_nxt = ST_BAD_PASSWORD;
				end else if (p1_r[7:0] != 8'h00 || !(p1_r[15:8] == ACK_ALL
					|| (p1_r[15:8] >= 8'h01 && p1_r[15:8] <= 8'(NUM_OUTPUTS)))) begin
					status_nxt = ST_BAD_PARAM;
				end
			end
			CMD_GET_EVENTS: begin
				if (count_r != CNT_GET_EVENTS) begin
					status_nxt = ST_BAD_COUNT;
				end else if (sec_r != SEC_NONE) begin
					status_nxt = ST_BAD_PARAM;
				end
			end
			CMD_PRESET_CRADLE, CMD_PRESET_GREASE, CMD_LIGHT, CMD_LOAD,
			CMD_PRESET_PULSE, CMD_PRESET_TEMP: begin
				case (code_r)
					CMD_LIGHT:        app_ok = app_enabled[APP_LIGHT];
					CMD_LOAD:         app_ok = app_enabled[APP_LOAD];
					CMD_PRESET_PULSE: app_ok = app_enabled[APP_PULSE];
					CMD_PRESET_TEMP:  app_ok = app_enabled[APP_COOL];
					default:          app_ok = app_enabled[APP_CRADLE];
				endcase
				if (!app_ok) begin
					status_nxt = ST_APP_OFF;
				end else if (!prot_ok) begin
					status_nxt = ST_BAD_PASSWORD;
				end
			end
			default: status_nxt = ST_BAD_CODE;
		endcase
	end

	// sequencing: go, check, execute
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r <= IOMC_IDLE;
		end else begin
			case (state_r)
				IOMC_IDLE:  state_r <= cmd_go ? IOMC_CHECK : IOMC_IDLE;
				IOMC_CHECK: state_r <= IOMC_EXEC;
				IOMC_EXEC:  state_r <= IOMC_IDLE;
				default:    state_r <= IOMC_IDLE;
			endcase
		end
	end

	// status write-back, latched in the check cycle so exec sees a stable value
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			last_code_r <= RST_WORD;
			status_r    <= ST_OK;
			cmd_done    <= 1'b0;
		end else begin
			cmd_done <= (state_r == IOMC_EXEC);
			if (state_r == IOMC_CHECK) begin
				last_code_r <= code_r;
				status_r    <= status_nxt;
			end
		end
	end

	// effects of a successful command
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			user_out      <= '0;
			alarm_reset   <= 1'b0;
			simple_cmd_en <= RST_SIMPLE_EN;
			unlatch       <= '0;
			app_cmd       <= 1'b0;
			events_req    <= 1'b0;
		end else begin
			alarm_reset <= 1'b0;
			unlatch     <= '0;
			app_cmd     <= 1'b0;
			events_req  <= 1'b0;
			if (state_r == IOMC_EXEC && status_r == ST_OK) begin
				case (code_r)
					CMD_SET_OUTPUT: begin
						for (int i = 0; i < NUM_OUTPUTS; i++) begin
							if (out_hot[i]) begin
								user_out[i] <= (p2_r == VAL_ON);
							end
						end
					end
					CMD_RESET_ALARMS: alarm_reset <= 1'b1;
					CMD_SIMPLE_EN:    simple_cmd_en <= p1_r[8];
					CMD_ACK_LATCH: begin
						if (p1_r[15:8] == ACK_ALL) begin
							unlatch <= '1;
						end else begin
							unlatch <= one_hot(p1_r[15:8]);
						end
					end
					CMD_GET_EVENTS:   events_req <= 1'b1;
					default:          app_cmd <= 1'b1;
				endcase
			end
		end
	end
endmodule

// File: src/iomc_pkg.sv
package iomc_pkg;
	// register word addresses of the command block
	localparam logic [15:0] ADDR_CMD_CODE    = 16'h1F3F;
	localparam logic [15:0] ADDR_PARAM_COUNT = 16'h1F40;
	localparam logic [15:0] ADDR_DEST        = 16'h1F41;
	localparam logic [15:0] ADDR_SEC_TYPE    = 16'h1F42;
	localparam logic [15:0] ADDR_PWD_HI      = 16'h1F43;
	localparam logic [15:0] ADDR_PWD_LO      = 16'h1F44;
	localparam logic [15:0] ADDR_PARAM_ONE   = 16'h1F45;
	localparam logic [15:0] ADDR_PARAM_TWO   = 16'h1F46;
	localparam logic [15:0] ADDR_LAST_CODE   = 16'h1F53;
	localparam logic [15:0] ADDR_STATUS      = 16'h1F54;
	// command codes
	localparam logic [15:0] CMD_SET_OUTPUT   = 16'h0688;
	localparam logic [15:0] CMD_RESET_ALARMS = 16'hA08B;
	localparam logic [15:0] CMD_SIMPLE_EN    = 16'hA08C;
	localparam logic [15:0] CMD_ACK_LATCH    = 16'hA08E;
	localparam logic [15:0] CMD_GET_EVENTS   = 16'hC580;
	localparam logic [15:0] CMD_PRESET_CRADLE = 16'hA188;
	localparam logic [15:0] CMD_PRESET_GREASE = 16'hA189;
	localparam logic [15:0] CMD_LIGHT        = 16'hA488;
	localparam logic [15:0] CMD_LOAD         = 16'hA588;
	localparam logic [15:0] CMD_PRESET_PULSE = 16'hA788;
	localparam logic [15:0] CMD_PRESET_TEMP  = 16'hA789;
	// parameter byte counts
	localparam logic [15:0] CNT_SET_OUTPUT   = 16'h000D;
	localparam logic [15:0] CNT_RESET_ALARMS = 16'h000A;
	localparam logic [15:0] CNT_SIMPLE_EN    = 16'h000B;
	localparam logic [15:0] CNT_ACK_LATCH    = 16'h000B;
	localparam logic [15:0] CNT_GET_EVENTS   = 16'h001B;
	// encodings
	localparam logic [15:0] SEC_PASSWORD     = 16'h0001;
	localparam logic [15:0] SEC_NONE         = 16'h0000;
	localparam logic [15:0] VAL_OFF          = 16'h0000;
	localparam logic [15:0] VAL_ON           = 16'h0100;
	localparam logic [15:0] DEST_MODULE_ONE  = 16'h2001;
	localparam logic [15:0] DEST_MODULE_TWO  = 16'h2101;
	localparam logic [7:0]  ACK_ALL          = 8'hFF;
	localparam int          NUM_OUTPUTS      = 3;
	// application bit positions in app_enabled
	localparam int APP_CRADLE = 0;
	localparam int APP_LIGHT  = 1;
	localparam int APP_LOAD   = 2;
	localparam int APP_PULSE  = 3;
	localparam int APP_COOL   = 4;
	localparam int NUM_APPS   = 5;
	// generic status codes (arbitrary values in the shared error set)
	localparam logic [15:0] ST_OK            = 16'h0000;
	localparam logic [15:0] ST_BAD_CODE      = 16'h0001;
	localparam logic [15:0] ST_BAD_COUNT     = 16'h0002;
	localparam logic [15:0] ST_BAD_PARAM     = 16'h0003;
	localparam logic [15:0] ST_BAD_PASSWORD  = 16'h0004;
	localparam logic [15:0] ST_APP_OFF       = 16'h0005;
	localparam logic [15:0] ST_NOT_ASSIGNED  = 16'h0006;
	localparam logic [15:0] ST_BAD_DEST      = 16'h0007;
	// reset values
	localparam logic [15:0] RST_WORD         = 16'h0000;
	localparam logic        RST_SIMPLE_EN    = 1'b1;

	typedef enum logic [1:0] {IOMC_IDLE, IOMC_CHECK, IOMC_EXEC} iomc_state_t;
endpackage

// File: tb/io_module_command_interpreter_test.sv
`timescale 1ns/1ps
module io_module_command_interpreter_test;
	import iomc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic        reg_wr, reg_rd, cmd_go, cmd_done, alarm_reset, simple_cmd_en, app_cmd, events_req;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, r;
	logic [15:0] module_dest = DEST_MODULE_ONE, dest = DEST_MODULE_ONE, sec = SEC_PASSWORD;
	logic [31:0] admin_password = 32'h1234_5678, operator_password = 32'h0BAD_CAFE, pwd = 32'h1234_5678;
	logic [4:0]  app_enabled = 5'h1F;
	logic [2:0]  user_output_mask = 3'h3, user_out, unlatch;
	int          num_errors = 0, samples_checked = 0;
	always #20 sys_clk = ~sys_clk;
	iomc_interp i_dut (.*);
	iomc_master i_mst (.*);
	task automatic tally_and_finish;
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// full block, start, bounded wait for completion, then status and code read back
	task automatic run(input logic [15:0] c, n, p1, p2, st, input logic [5:0] fx);
		logic [15:0] w[8];
		int k;
		w = '{c, n, dest, sec, pwd[31:16], pwd[15:0], p1, p2};
		foreach (w[i]) i_mst.wr(ADDR_CMD_CODE + 16'(i), w[i]);
		i_mst.go();
		for (k = 0; k < 8 && cmd_done !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		chk("cmd_done", {15'h0, cmd_done}, 16'h1);
		if (cmd_done !== 1'b1) tally_and_finish();
		chk("effects", {10'h0, alarm_reset, unlatch, app_cmd, events_req}, {10'h0, fx});
		i_mst.rd(ADDR_STATUS, r);
		chk("status", r, st);
		i_mst.rd(ADDR_LAST_CODE, r);
		chk("last_code", r, c);
	endtask
	task automatic t_reset;
		chk("simple_en", {15'h0, simple_cmd_en}, 16'h1);
		chk("user_out", {13'h0, user_out}, 16'h0);
		i_mst.rd(16'h1F50, r);
		chk("unmapped", r, 16'h0);
	endtask
	task automatic t_output;
		run(CMD_SET_OUTPUT, CNT_SET_OUTPUT, 16'h2, VAL_ON, ST_OK, 6'h0);
		chk("user_out", {13'h0, user_out}, 16'h2);
		run(CMD_SET_OUTPUT, CNT_SET_OUTPUT, 16'h3, VAL_ON, ST_NOT_ASSIGNED, 6'h0);
		run(CMD_SET_OUTPUT, CNT_SET_OUTPUT, 16'h4, VAL_ON, ST_BAD_PARAM, 6'h0);
		run(CMD_SET_OUTPUT, CNT_SET_OUTPUT, 16'h1, 16'h1, ST_BAD_PARAM, 6'h0);
		run(CMD_SET_OUTPUT, 16'hC, 16'h1, VAL_ON, ST_BAD_COUNT, 6'h0);
		run(CMD_SET_OUTPUT, CNT_SET_OUTPUT, 16'h2, VAL_OFF, ST_OK, 6'h0);
		chk("user_out", {13'h0, user_out}, 16'h0);
	endtask
	task automatic t_alarm;
		pwd = operator_password;
		run(CMD_RESET_ALARMS, CNT_RESET_ALARMS, 16'h0, 16'h0, ST_OK, 6'h20);
		pwd = ~operator_password;
		run(CMD_RESET_ALARMS, CNT_RESET_ALARMS, 16'h0, 16'h0, ST_BAD_PASSWORD, 6'h0);
		sec = SEC_NONE;
		pwd = admin_password;
		run(CMD_RESET_ALARMS, CNT_RESET_ALARMS, 16'h0, 16'h0, ST_BAD_PASSWORD, 6'h0);
		sec = SEC_PASSWORD;
	endtask
	task automatic t_simple;
		run(CMD_SIMPLE_EN, CNT_SIMPLE_EN, 16'h0, 16'h0, ST_OK, 6'h0);
		chk("simple_en", {15'h0, simple_cmd_en}, 16'h0);
		run(CMD_SIMPLE_EN, CNT_SIMPLE_EN, 16'h0101, 16'h0, ST_BAD_PARAM, 6'h0);
		run(CMD_SIMPLE_EN, CNT_SIMPLE_EN, 16'h0100, 16'h0, ST_OK, 6'h0);
		chk("simple_en", {15'h0, simple_cmd_en}, 16'h1);
	endtask
	task automatic t_ack;
		dest = DEST_MODULE_TWO;
		run(CMD_ACK_LATCH, CNT_ACK_LATCH, 16'h0100, 16'h0, ST_BAD_DEST, 6'h0);
		dest = DEST_MODULE_ONE;
		run(CMD_ACK_LATCH, CNT_ACK_LATCH, 16'h0200, 16'h0, ST_OK, 6'h08);
		run(CMD_ACK_LATCH, CNT_ACK_LATCH, 16'hFF00, 16'h0, ST_OK, 6'h1C);
		run(CMD_ACK_LATCH, CNT_ACK_LATCH, 16'h0400, 16'h0, ST_BAD_PARAM, 6'h0);
		run(CMD_ACK_LATCH, CNT_ACK_LATCH, 16'h0301, 16'h0, ST_BAD_PARAM, 6'h0);
		@(posedge sys_clk) module_dest <= DEST_MODULE_TWO;
		dest = DEST_MODULE_TWO;
		run(CMD_ACK_LATCH, CNT_ACK_LATCH, 16'h0300, 16'h0, ST_OK, 6'h10);
	endtask
	task automatic t_app;
		logic [15:0] codes[6] = '{CMD_PRESET_CRADLE, CMD_PRESET_GREASE, CMD_LIGHT, CMD_LOAD, CMD_PRESET_PULSE,
			CMD_PRESET_TEMP};
		int bits[6] = '{APP_CRADLE, APP_CRADLE, APP_LIGHT, APP_LOAD, APP_PULSE, APP_COOL};
		foreach (codes[i]) begin
			@(posedge sys_clk) app_enabled <= 5'h1F;
			run(codes[i], 16'h0, 16'h0, 16'h0, ST_OK, 6'h02);
			@(posedge sys_clk) app_enabled <= ~(5'h01 << bits[i]);
			run(codes[i], 16'h0, 16'h0, 16'h0, ST_APP_OFF, 6'h0);
		end
		@(posedge sys_clk) app_enabled <= 5'h00;
		run(CMD_RESET_ALARMS, CNT_RESET_ALARMS, 16'h0, 16'h0, ST_OK, 6'h20);
	endtask
	task automatic t_events;
		sec = SEC_NONE;
		pwd = 32'hFFFF_FFFF;
		run(CMD_GET_EVENTS, CNT_GET_EVENTS, 16'h0, 16'h0, ST_OK, 6'h01);
		sec = SEC_PASSWORD;
		pwd = admin_password;
		run(16'h1234, 16'hA, 16'h0, 16'h0, ST_BAD_CODE, 6'h0);
		run(16'hA78A, 16'hA, 16'h0, 16'h0, ST_BAD_CODE, 6'h0);
		i_mst.rd(ADDR_CMD_CODE, r);
		chk("code_reg", r, 16'hA78A);
		i_mst.rd(ADDR_PARAM_COUNT, r);
		chk("count_reg", r, 16'h000A);
		i_mst.rd(ADDR_PWD_HI, r);
		chk("pwd_hi_reg", r, admin_password[31:16]);
		i_mst.rd(ADDR_PWD_LO, r);
		chk("pwd_lo_reg", r, admin_password[15:0]);
	endtask
	initial begin
		@(posedge sys_clk);
		@(posedge sys_clk) srst <= 1'b0;
		t_reset();
		t_output();
		t_alarm();
		t_simple();
		t_ack();
		t_app();
		t_events();
		tally_and_finish();
	end
endmodule

// File: tb/iomc_assertions.sv
`timescale 1ns/1ps
module iomc_assertions
	import iomc_pkg::*;
(
	input wire logic                       sys_clk,
	input wire logic                       srst,
	input wire logic                       cmd_go,
	input wire logic                       cmd_done,
	input wire logic [NUM_OUTPUTS-1:0]     user_out,
	input wire logic [NUM_OUTPUTS-1:0]     user_output_mask,
	input wire logic [NUM_APPS-1:0]        app_enabled,
	input wire logic                       alarm_reset,
	input wire logic                       simple_cmd_en,
	input wire logic [NUM_OUTPUTS-1:0]     unlatch,
	input wire logic                       app_cmd,
	input wire logic                       events_req
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_done_go; cmd_done |-> $past(cmd_go, 3); endproperty
	a_done_go: assert property (p_done_go) else $error("done without start three cycles before");
	property p_done_pulse; cmd_done |=> !cmd_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_alarm; alarm_reset |-> cmd_done; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm clear outside completion");
	property p_unlatch; |unlatch |-> cmd_done ##1 (unlatch == 3'h0); endproperty
	a_unlatch: assert property (p_unlatch) else $error("unlatch not a completion pulse");
	property p_app; app_cmd |-> cmd_done && (app_enabled != 5'h00); endproperty
	a_app: assert property (p_app) else $error("application command with nothing configured");
	property p_events; events_req |-> cmd_done; endproperty
	a_events: assert property (p_events) else $error("event request outside completion");
	property p_out_hold; !cmd_done |-> $stable(user_out); endproperty
	a_out_hold: assert property (p_out_hold) else $error("outputs moved without a command");
	property p_out_mask; cmd_done |-> ((user_out ^ $past(user_out)) & ~user_output_mask) == 3'h0; endproperty
	a_out_mask: assert property (p_out_mask) else $error("output outside user mask changed");
	property p_simple_hold; !cmd_done |-> $stable(simple_cmd_en); endproperty
	a_simple_hold: assert property (p_simple_hold) else $error("simple enable moved without a command");
	c_alarm: cover property (alarm_reset);
	c_unlatch: cover property (unlatch == 3'h7);
	c_events: cover property (events_req);
endmodule
bind iomc_interp iomc_assertions i_chk (.*);

// File: tb/iomc_master.sv
`timescale 1ns/1ps
module iomc_master
	import iomc_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic [15:0] reg_rdata,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [15:0]      reg_addr,
	output logic [15:0]      reg_wdata,
	output logic             cmd_go
);
	initial {reg_wr, reg_rd, cmd_go, reg_addr, reg_wdata} = 35'h0;
	// one word per strobe, field values come from the caller
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d; // released data never shows the stale word
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic go;
		@(posedge sys_clk);
		cmd_go <= 1'b1;
		@(posedge sys_clk);
		cmd_go <= 1'b0;
	endtask
endmodule
